/* File: rtl/frs_defines.vh */
// Constants for the flash power-on and reset sequencer.
// Assumes a 50 ns system clock and a 32-bit APB register port.
`ifndef FRS_DEFINES_VH
`define FRS_DEFINES_VH

`define FRS_CLK_NS 50
`define FRS_TICK_NS 25000
`define FRS_SETTLE_US 300
`define FRS_RECOV_US 30
`define FRS_TICK_US 25

`define FRS_ST_POR 3'h0
`define FRS_ST_RECOV 3'h1
`define FRS_ST_EXT 3'h2
`define FRS_ST_HWRST 3'h3
`define FRS_ST_STANDBY 3'h4

`define FRS_OFS_CTRL 8'h00
`define FRS_OFS_STATUS 8'h04
`define FRS_OFS_EXT 8'h08

`define FRS_CTRL_SWRST 0
`define FRS_STS_OTPLOCK 4
`define FRS_STS_OTPFAIL 5
`define FRS_STS_PORBAD 6
`define FRS_STS_COLD 7

`define FRS_EXT_RESET 16'hFFFF
`define FRS_EXT_NONE 16'hFFFF

`endif

/* File: rtl/frs_sequencer.v */
// Power-on (cold) and hardware (warm) reset sequencer of a serial flash.
// Assumes synchronous supply-detector levels and host pins, and an APB master.
//
// Functional notes
// - After supplies are good, ignore all inputs until the settle time elapses.
// - Fall below reinit threshold then recovery starts power-on reset, cold algorithm.
// - Core supply below lockout refuses every program and erase operation.
// - Dip staying above lockout keeps initialised state, no reinitialisation.
// - A software reset command recovers from a bad power-up lock-up; here it runs only the warm recovery and leaves porBad_q set.
// - During settle and extension ignore hardware reset, chip select, commands.
// - In power-on reset: not selectable, no commands, only reset output driven.
// - Reset low during power-on ends after both settle and recovery times.
// - At settle end stay in hardware reset if reset low, else standby.
// - Chip select level during settle does not affect the cold reset.
// - Incomplete power-on makes a later hardware reset run the cold reset.
// - Reset output pulled low during power-on, released after internal reset and extension.
// - Standby at once on reset output release; no commands while it is low.
// - Sixteen-bit extension register defaults to all ones, meaning no added time.
// - Extension lasts register value plus one ticks of the extension clock.
// - Extension register is one-time programmable; later programming attempts fail.
// - Interrupt output is high impedance once supply reaches its minimum.
// - Hardware reset aborts operations, exits overlay, tristates outputs, idles controller.
// - Hardware reset clears the status register to its reset value.
// - Chip select ignored during recovery; host keeps it high meanwhile.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "frs_defines.vh"

module frs_sequencer #(
    parameter TICK_CYCLES = `FRS_TICK_NS / `FRS_CLK_NS,
    parameter SETTLE_TICKS = (`FRS_SETTLE_US + `FRS_TICK_US - 1) / `FRS_TICK_US,
    parameter RECOV_TICKS = (`FRS_RECOV_US + `FRS_TICK_US - 1) / `FRS_TICK_US
) (
    input wire sys_clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire supplyOk,
    input wire belowLockout,
    input wire belowReinit,
    input wire hwResetN,
    input wire chipSelN,
    output reg resetOutOe,
    output reg intOe,
    output reg dataOe,
    output reg selectEn,
    output reg cmdEn,
    output reg pgmEraseEn,
    output reg abortOp,
    output reg asoExit,
    output reg statusClr,
    output reg [2:0] seqState
);

    // Sequencer state, settle and extension timing, and supply bookkeeping.
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [15:0] tickDiv_q;
    reg [15:0] timer_q;
    reg [15:0] timer_d;
    reg timerLoad;
    reg tick_q;
    reg cold_q;
    reg cold_d;
    reg hwSeen_q;
    reg hwSeen_d;
    reg reinitPend_q;
    reg porBad_q;
    reg [15:0] extReg_q;
    reg otpLock_q;
    reg otpFail_q;
    reg swReset;
    reg resetEntry;
    wire apbWrite;
    wire apbSetup;
    wire timerDone;
    wire extNone;
    wire [15:0] extTicks;

    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pready & pwrite;
    // A timed period ends on the tick that would take the timer to zero.
    assign timerDone = tick_q && (timer_q == 16'h0001);
    // All ones in the extension register means no added reset time.
    assign extNone = (extReg_q == `FRS_EXT_NONE);
    assign extTicks = extReg_q + 16'h0001;

    // The tick divider restarts on every timer load, so a timed period is
    // never short by a partial tick; it may be long by at most one sys_clk.
    // The tick period has to stay within the allowed extension clock range.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tickDiv_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (timerLoad || tickDiv_q == TICK_CYCLES[15:0] - 16'h0001) begin
            tickDiv_q <= 16'h0000;
            tick_q <= ~timerLoad;
        end else begin
            tickDiv_q <= tickDiv_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // Supply tracking: only a fall below the reinit threshold asks for a
    // cold restart, a dip below lockout alone marks power-on as unreliable.
    // A dip that stays above lockout touches neither flag, so the device
    // keeps its initialised state and carries on once supply is back.
    // The unreliable mark is cleared only by a settle that ends with supply good.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reinitPend_q <= 1'b0;
            porBad_q <= 1'b0;
        end else begin
            if (belowReinit) begin
                reinitPend_q <= 1'b1;
            end else if (state_q == `FRS_ST_POR) begin
                reinitPend_q <= 1'b0;
            end
            if (belowLockout && !belowReinit) begin
                porBad_q <= 1'b1;
            end else if (state_q == `FRS_ST_POR && timerDone && supplyOk) begin
                porBad_q <= 1'b0;
            end
        end
    end

    always @* begin
        state_d = state_q;
        timer_d = timer_q;
        timerLoad = 1'b0;
        cold_d = cold_q;
        hwSeen_d = hwSeen_q;
        resetEntry = 1'b0;
        if (tick_q && timer_q != 16'h0000) begin
            timer_d = timer_q - 16'h0001;
        end
        if (reinitPend_q && supplyOk && !belowReinit) begin
            state_d = `FRS_ST_POR;
            timer_d = SETTLE_TICKS[15:0];
            timerLoad = 1'b1;
            cold_d = 1'b1;
            hwSeen_d = 1'b0;
        end else begin
            case (state_q)
                `FRS_ST_POR: begin
                    // Chip select is never looked at here, so its level cannot
                    // steer the cold reset; a low reset pin is only remembered.
                    if (!hwResetN) begin
                        hwSeen_d = 1'b1;
                    end
                    if (!supplyOk) begin
                        timer_d = SETTLE_TICKS[15:0];
                        timerLoad = 1'b1;
                    end else if (timerDone) begin
                        timerLoad = 1'b1;
                        if (hwSeen_q || !hwResetN) begin
                            state_d = `FRS_ST_RECOV;
                            timer_d = RECOV_TICKS[15:0];
                        end else if (!extNone) begin
                            state_d = `FRS_ST_EXT;
                            timer_d = extTicks;
                        end else begin
                            state_d = `FRS_ST_STANDBY;
                            cold_d = 1'b0;
                        end
                    end
                end
                `FRS_ST_RECOV: begin
                    // Chip select is ignored for the whole recovery time.
                    if (timerDone) begin
                        timerLoad = 1'b1;
                        // After a cold recovery the extension still has to run.
                        if (cold_q && !extNone) begin
                            state_d = `FRS_ST_EXT;
                            timer_d = extTicks;
                        end else if (!hwResetN) begin
                            state_d = `FRS_ST_HWRST;
                            cold_d = 1'b0;
                        end else begin
                            state_d = `FRS_ST_STANDBY;
                            cold_d = 1'b0;
                        end
                    end
                end
                `FRS_ST_EXT: begin
                    // Reset input is ignored until the extension has run out.
                    if (timerDone) begin
                        cold_d = 1'b0;
                        if (!hwResetN) begin
                            state_d = `FRS_ST_HWRST;
                        end else begin
                            state_d = `FRS_ST_STANDBY;
                        end
                    end
                end
                `FRS_ST_HWRST: begin
                    // Recovery or the extension has already run, so leaving needs no timer of its own.
                    if (hwResetN) begin
                        state_d = `FRS_ST_STANDBY;
                    end
                end
                `FRS_ST_STANDBY: begin
                    if (!hwResetN || swReset) begin
                        resetEntry = 1'b1;
                        timerLoad = 1'b1;
                        // A hardware reset with power-on marked unreliable reruns the cold algorithm.
                        if (porBad_q && !hwResetN) begin
                            state_d = `FRS_ST_POR;
                            timer_d = SETTLE_TICKS[15:0];
                            cold_d = 1'b1;
                            hwSeen_d = 1'b1;
                        end else begin
                            state_d = `FRS_ST_RECOV;
                            timer_d = RECOV_TICKS[15:0];
                        end
                    end
                end
                default: begin
                    // An illegal state code restarts a full cold reset rather than guessing.
                    state_d = `FRS_ST_POR;
                    timer_d = SETTLE_TICKS[15:0];
                    timerLoad = 1'b1;
                    cold_d = 1'b1;
                end
            endcase
        end
    end

    // Releasing rst_b stands for power arriving, so the sequencer starts in
    // power-on reset with a full settle time loaded.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= `FRS_ST_POR;
            timer_q <= SETTLE_TICKS[15:0];
            cold_q <= 1'b1;
            hwSeen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            cold_q <= cold_d;
            hwSeen_q <= hwSeen_d;
        end
    end

    // Pin-facing outputs, all registered from the next state, except the reset side-effect pulses, which come from resetEntry.
    // Deriving them from the next state keeps them in step with seqState
    // instead of one cycle behind it.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            resetOutOe <= 1'b1;
            intOe <= 1'b0;
            dataOe <= 1'b0;
            selectEn <= 1'b0;
            cmdEn <= 1'b0;
            pgmEraseEn <= 1'b0;
            abortOp <= 1'b0;
            asoExit <= 1'b0;
            statusClr <= 1'b0;
            seqState <= `FRS_ST_POR;
        end else begin
            resetOutOe <= (state_d == `FRS_ST_POR) || (state_d == `FRS_ST_EXT)
                || (state_d == `FRS_ST_RECOV && cold_d);
            intOe <= 1'b0;
            dataOe <= (state_d == `FRS_ST_STANDBY) && hwResetN;
            selectEn <= (state_d == `FRS_ST_STANDBY);
            cmdEn <= (state_d == `FRS_ST_STANDBY) && !chipSelN;
            pgmEraseEn <= (state_d == `FRS_ST_STANDBY) && !belowLockout;
            abortOp <= resetEntry;
            asoExit <= resetEntry;
            statusClr <= resetEntry;
            seqState <= state_d;
        end
    end

    // Register port: zero wait states, read data captured in the setup cycle.
    // A software reset request is only acted on in standby.
    always @* begin
        swReset = apbWrite && (paddr == `FRS_OFS_CTRL) && pwdata[`FRS_CTRL_SWRST];
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apbSetup;
            // Unmapped offsets answer with an error and change nothing.
            pslverr <= apbSetup && (paddr != `FRS_OFS_CTRL)
                && (paddr != `FRS_OFS_STATUS) && (paddr != `FRS_OFS_EXT);
            if (apbSetup && !pwrite) begin
                case (paddr)
                    `FRS_OFS_STATUS: begin
                        prdata <= {24'h000000, cold_q, porBad_q, otpFail_q,
                            otpLock_q, 1'b0, state_q};
                    end
                    `FRS_OFS_EXT: begin
                        prdata <= {16'h0000, extReg_q};
                    end
                    default: begin
                        prdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // The extension register is programmable once; a second attempt leaves
    // it unchanged and raises a sticky failure flag (write one to clear, but
    // a new failure in the same cycle wins).
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            extReg_q <= `FRS_EXT_RESET;
            otpLock_q <= 1'b0;
            otpFail_q <= 1'b0;
        end else begin
            if (apbWrite && paddr == `FRS_OFS_EXT) begin
                if (otpLock_q) begin
                    otpFail_q <= 1'b1;
                end else begin
                    extReg_q <= pwdata[15:0];
                    otpLock_q <= 1'b1;
                end
            end else if (apbWrite && paddr == `FRS_OFS_STATUS
                    && pwdata[`FRS_STS_OTPFAIL]) begin
                otpFail_q <= 1'b0;
            end
        end
    end

endmodule

/* File: dv/frs_sequencer_assertions.sv */
// Checker for the reset sequencer, watching only its ports.
// Assumes the bind below and the parameter values of the bound instance.
`timescale 1ns/1ps
`include "frs_defines.vh"
module frs_sequencer_checker #(
    parameter TICK_CYCLES = 500,
    parameter SETTLE_TICKS = 12
) (
    input wire sys_clk,
    input wire rst_b,
    input wire hwResetN,
    input wire chipSelN,
    input wire belowLockout,
    input wire resetOutOe,
    input wire intOe,
    input wire dataOe,
    input wire selectEn,
    input wire cmdEn,
    input wire pgmEraseEn,
    input wire abortOp,
    input wire asoExit,
    input wire statusClr,
    input wire [2:0] seqState
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    int lowCnt_q;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) lowCnt_q <= 0;
        else lowCnt_q <= resetOutOe ? lowCnt_q + 1 : 0;
    end
    property p_settle; $fell(resetOutOe) |-> lowCnt_q >= SETTLE_TICKS * TICK_CYCLES - 1; endproperty
    a_settle: assert property (p_settle) else $error("reset output released early");
    property p_int; !intOe; endproperty
    a_int: assert property (p_int) else $error("interrupt output driven");
    property p_sel; selectEn |-> seqState == `FRS_ST_STANDBY && !resetOutOe; endproperty
    a_sel: assert property (p_sel) else $error("selectable outside standby");
    property p_cmd; cmdEn |-> !resetOutOe && seqState == `FRS_ST_STANDBY; endproperty
    a_cmd: assert property (p_cmd) else $error("commands open during reset");
    property p_csgate; cmdEn |-> !$past(chipSelN); endproperty
    a_csgate: assert property (p_csgate) else $error("commands open with select high");
    property p_lock; $past(belowLockout) |-> !pgmEraseEn; endproperty
    a_lock: assert property (p_lock) else $error("program allowed below lockout");
    property p_tri; !$past(hwResetN) |-> !dataOe; endproperty
    a_tri: assert property (p_tri) else $error("outputs driven in reset");
    property p_pulse; abortOp |-> asoExit && statusClr ##1 !abortOp; endproperty
    a_pulse: assert property (p_pulse) else $error("reset side effects incomplete");
    property p_release; $fell(resetOutOe) && hwResetN |-> ##[0:1] seqState == `FRS_ST_STANDBY;
    endproperty
    a_release: assert property (p_release) else $error("no standby at release");
endmodule
bind frs_sequencer frs_sequencer_checker #(.TICK_CYCLES(TICK_CYCLES),
    .SETTLE_TICKS(SETTLE_TICKS)) u_frs_sequencer_checker (.sys_clk, .rst_b, .hwResetN,
    .chipSelN, .belowLockout, .resetOutOe, .intOe, .dataOe, .selectEn, .cmdEn,
    .pgmEraseEn, .abortOp, .asoExit, .statusClr, .seqState);

/* File: dv/frs_host_model.sv */
// Host controller model driving the hardware reset and chip-select pins.
// Assumes the bench raises resetReq and csReq as levels; rude lets select through.
`timescale 1ns/1ps
module frs_host_model #(
    parameter int PULSE = 4,
    parameter int GUARD = 12
) (
    input wire logic sys_clk,
    input wire logic resetReq,
    input wire logic csReq,
    input wire logic rude,
    input wire logic resetOutOe,
    output logic hwResetN,
    output logic chipSelN
);
    int pulseCnt = 0;
    int holdCnt = 0;
    initial hwResetN = 1'b1;
    initial chipSelN = 1'b1;
    always @(posedge sys_clk) begin
        pulseCnt <= resetReq ? PULSE : (pulseCnt > 0 ? pulseCnt - 1 : 0);
        hwResetN <= !(resetReq || pulseCnt > 1);
        holdCnt <= !hwResetN ? GUARD : (holdCnt > 0 ? holdCnt - 1 : 0);
        chipSelN <= !(csReq && (rude || (holdCnt == 0 && hwResetN && !resetOutOe)));
    end
endmodule

/* File: dv/tb_frs_sequencer.sv */
// Self-checking bench for the reset sequencer with a host model on its pins.
// Assumes a shortened tick so every settle and extension stays short.
`timescale 1ns/1ps
`include "frs_defines.vh"
module tb_frs_sequencer;
    localparam int TICK = 4;
    localparam int SETTLE = 12 * TICK;
    localparam int EXT = 4 * TICK;
    logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic supplyOk = 1, belowLockout = 0, belowReinit = 0;
    logic resetReq = 0, csReq = 0, rude = 0, sawAbort = 0;
    wire hwResetN, chipSelN, pready, pslverr, resetOutOe, intOe, dataOe, selectEn, cmdEn;
    wire pgmEraseEn, abortOp, asoExit, statusClr;
    wire [31:0] prdata;
    wire [2:0] seqState;
    int n_fail = 0, total_checks = 0, cyc = 0, n;
    frs_sequencer #(.TICK_CYCLES(TICK), .SETTLE_TICKS(12), .RECOV_TICKS(2)) u_frs_sequencer (
        .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .supplyOk, .belowLockout, .belowReinit, .hwResetN, .chipSelN,
        .resetOutOe, .intOe, .dataOe, .selectEn, .cmdEn, .pgmEraseEn, .abortOp,
        .asoExit, .statusClr, .seqState);
    frs_host_model #(.PULSE(4), .GUARD(3 * TICK)) u_frs_host_model (.sys_clk, .resetReq,
        .csReq, .rude, .resetOutOe, .hwResetN, .chipSelN);
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (abortOp === 1'b1) sawAbort <= 1'b1;
        if (cyc == 5000) begin
            n_fail++;
            summarize();
        end
    end
    task summarize();
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task porLen(output int c);
        c = 0;
        while (resetOutOe !== 1'b0) begin
            @(posedge sys_clk);
            c++;
        end
        repeat (2) @(posedge sys_clk);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1;
        csReq <= 1;
        rude <= 1;
        @(posedge sys_clk);
        chk(resetOutOe, 1);
        chk(selectEn, 0);
        repeat (SETTLE / 2) @(posedge sys_clk);
        chk(cmdEn, 0);
        rude <= 0;
        porLen(n);
        n = n + SETTLE / 2;
        chk(n >= SETTLE - 2 && n <= SETTLE + TICK + 4, 1);
        chk(seqState, `FRS_ST_STANDBY);
        repeat (3) @(posedge sys_clk);
        chk({selectEn, cmdEn, pgmEraseEn}, 3'h7);
        apb(0, `FRS_OFS_EXT, 0);
        chk(rd, 32'h0000FFFF);
        apb(1, `FRS_OFS_EXT, 32'h00000003);
        apb(1, `FRS_OFS_EXT, 32'h00000001);
        apb(0, `FRS_OFS_EXT, 0);
        chk(rd, 32'h00000003);
        apb(0, `FRS_OFS_STATUS, 0);
        chk(rd[`FRS_STS_OTPFAIL], 1);
        apb(0, 8'h0C, 0);
        chk(err, 1);
        resetReq <= 1;
        repeat (20) @(posedge sys_clk);
        chk({seqState, dataOe, cmdEn, sawAbort}, {`FRS_ST_HWRST, 3'h1});
        resetReq <= 0;
        repeat (16) @(posedge sys_clk);
        chk(seqState, `FRS_ST_STANDBY);
        chk(pgmEraseEn, 1);
        apb(1, `FRS_OFS_CTRL, 32'h00000001);
        repeat (2) @(posedge sys_clk);
        chk(seqState, `FRS_ST_RECOV);
        repeat (14) @(posedge sys_clk);
        chk(seqState, `FRS_ST_STANDBY);
        supplyOk <= 0;
        repeat (3) @(posedge sys_clk);
        supplyOk <= 1;
        repeat (2) @(posedge sys_clk);
        chk({seqState, resetOutOe}, {`FRS_ST_STANDBY, 1'b0});
        belowLockout <= 1;
        repeat (3) @(posedge sys_clk);
        chk({pgmEraseEn, seqState}, {1'b0, `FRS_ST_STANDBY});
        belowLockout <= 0;
        repeat (3) @(posedge sys_clk);
        chk(pgmEraseEn, 1);
        resetReq <= 1;
        repeat (4) @(posedge sys_clk);
        resetReq <= 0;
        repeat (2) @(posedge sys_clk);
        chk({seqState, resetOutOe}, {`FRS_ST_POR, 1'b1});
        porLen(n);
        chk(n >= SETTLE + EXT - 10 && n <= SETTLE + EXT + 3 * TICK, 1);
        supplyOk <= 0;
        belowReinit <= 1;
        repeat (4) @(posedge sys_clk);
        supplyOk <= 1;
        belowReinit <= 0;
        repeat (2) @(posedge sys_clk);
        chk(seqState, `FRS_ST_POR);
        porLen(n);
        chk(n >= SETTLE + EXT - 2 && n <= SETTLE + EXT + 8, 1);
        chk(intOe, 0);
        summarize();
    end
endmodule
